// ==== tb/move_nop_irq_return_exec_tb.sv ====
// move_nop_irq_return_exec_tb: directed bench for the move/idle/interrupt-return executor
// assumes mnrx_exec holds its own file store; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %0t got %0h expected %0h", $time, got, exp); end end
module move_nop_irq_return_exec_tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_valid = 1'b0;
  logic [13:0] i_insn = 14'h0000;
  logic [6:0] i_pre_addr = 7'h00;
  logic [12:0] i_stack_top = 13'h1A5C;
  logic o_stack_pop, o_zero, o_busy;
  logic [7:0] o_acc, o_intctl;
  logic [12:0] o_pc;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] e_acc = 8'h00;
  logic [7:0] e_ctl = 8'h00;
  logic e_zero = 1'b0;
  logic [12:0] e_pc = 13'h0000;

  mnrx_exec dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_insn(i_insn),
    .i_pre_addr(i_pre_addr), .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop), .o_acc(o_acc),
    .o_zero(o_zero), .o_intctl(o_intctl), .o_pc(o_pc), .o_busy(o_busy));

  // 125 MHz clock
  always #4 i_clk = ~i_clk;

  // hang guard: whole run needs well under 200 cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // address leads by a cycle because the file read is registered
  task automatic step(input logic [13:0] insn);
    @(negedge i_clk);
    i_pre_addr = insn[6:0];
    @(negedge i_clk);
    i_valid = 1'b1;
    i_insn = insn;
    @(negedge i_clk);
    i_valid = 1'b0;
    e_pc = e_pc + 13'h0001;
  endtask

  task automatic check_state();
    `CHK(o_acc, e_acc)
    `CHK(o_zero, e_zero)
    `CHK(o_intctl, e_ctl)
    `CHK(o_pc, e_pc)
    `CHK(o_busy, 1'b0)
    `CHK(o_stack_pop, 1'b0)
  endtask

  // a zero literal must leave the zero flag alone
  task automatic t_literal();
    step(14'h305A);
    e_acc = 8'h5A;
    check_state();
    step(14'h3000);
    e_acc = 8'h00;
    check_state();
    step(14'h33FF);
    e_acc = 8'hFF;
    check_state();
    $display("test literal done");
  endtask

  // top and bottom file addresses, both destinations, zero set and cleared
  task automatic t_store_copy();
    step(14'h30A5);
    e_acc = 8'hA5;
    step(14'h00FF);
    check_state();
    step(14'h3000);
    e_acc = 8'h00;
    step(14'h0080);
    step(14'h3033);
    e_acc = 8'h33;
    step(14'h0880);
    e_zero = 1'b1;
    check_state();
    step(14'h0800);
    e_acc = 8'h00;
    check_state();
    step(14'h08FF);
    e_zero = 1'b0;
    check_state();
    step(14'h087F);
    e_acc = 8'hA5;
    check_state();
    step(14'h0800);
    e_acc = 8'h00;
    e_zero = 1'b1;
    check_state();
    step(14'h00C5);
    check_state();
    $display("test store_copy done");
  endtask

  task automatic t_idle();
    step(14'h0000);
    check_state();
    step(14'h0000);
    check_state();
    $display("test idle done");
  endtask

  // store then copy of one register in consecutive cycles; the copy must see the new byte
  task automatic t_burst();
    step(14'h3000);
    e_acc = 8'h00;
    step(14'h0092);
    step(14'h305C);
    e_acc = 8'h5C;
    check_state();
    @(negedge i_clk);
    i_pre_addr = 7'h12;
    i_valid = 1'b1;
    i_insn = 14'h0092;
    @(negedge i_clk);
    i_insn = 14'h0812;
    @(negedge i_clk);
    i_valid = 1'b0;
    e_pc = e_pc + 13'h0002;
    e_zero = 1'b0;
    check_state();
    $display("test burst done");
  endtask

  // a literal is held on the bus through the flush cycle and must be dropped
  task automatic t_iret();
    @(negedge i_clk);
    i_valid = 1'b1;
    i_insn = 14'h0009;
    @(negedge i_clk);
    i_insn = 14'h3077;
    e_pc = 13'h1A5C;
    e_ctl = 8'h80;
    `CHK(o_pc, e_pc)
    `CHK(o_stack_pop, 1'b1)
    `CHK(o_intctl, e_ctl)
    `CHK(o_busy, 1'b1)
    `CHK(o_zero, e_zero)
    @(negedge i_clk);
    i_valid = 1'b0;
    check_state();
    step(14'h3077);
    e_acc = 8'h77;
    check_state();
    $display("test iret done");
  endtask

  initial
  begin
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    check_state();
    t_literal();
    t_store_copy();
    t_idle();
    t_burst();
    t_iret();
    conclude();
  end
endmodule
`default_nettype wire

// ==== verilog/mnrx_exec.sv ====
// mnrx_exec: executes copy-file, store-acc, load-literal, idle and interrupt-return
// assumes the fetch stage holds i_insn steady and presents the operand address a cycle ahead on i_pre_addr
//
// Contract
// - copy_file_to_dest reads the file register addressed by the 7-bit operand (0..127).
// - copy_file_to_dest writes to the accumulator when the destination bit is 0, back to the file when 1.
// - copy_file_to_dest sets the zero flag when the copied value is zero and clears it otherwise.
// - store_acc_to_file writes the accumulator into the addressed file register and touches no flag.
// - load_literal_acc puts the 8-bit immediate into the accumulator and touches no flag.
// - interrupt_return pops the stack and loads stack_top_entry into the program counter.
// - interrupt_return sets global_interrupt_allow, bit 7 of the interrupt control register.
// - interrupt_return takes two instruction cycles and leaves the flags alone.
`timescale 1ns/1ns
`default_nettype none
module mnrx_exec (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // instruction from fetch
  input wire logic i_valid,
  input wire logic [13:0] i_insn,
  input wire logic [6:0] i_pre_addr,
  // stack
  input wire logic [12:0] i_stack_top,
  output logic o_stack_pop,
  // architectural state
  output logic [7:0] o_acc,
  output logic o_zero,
  output logic [7:0] o_intctl,
  output logic [12:0] o_pc,
  output logic o_busy
);
  mnrx_wb_if wb ();

  mnrx_file_mem #(.DEPTH(128)) u_mem (
    .i_clk(i_clk),
    .port(wb.mem)
  );

  // opcode decode
  wire logic is_idle = i_insn == mnrx_pkg::OP_IDLE;
  wire logic is_iret = i_insn == mnrx_pkg::OP_IRET;
  wire logic is_copy = i_insn[13:8] == mnrx_pkg::OP_COPY_HI;
  wire logic is_store = i_insn[13:7] == mnrx_pkg::OP_STORE_HI;
  wire logic is_lit = i_insn[13:10] == mnrx_pkg::OP_LIT_HI;
  wire logic dest_file = i_insn[mnrx_pkg::DEST_BIT];
  wire logic [6:0] f_addr = i_insn[6:0];
  wire logic [7:0] literal = i_insn[7:0];

  mnrx_pkg::mnrx_state_t state_q, state_d;
  logic [7:0] acc_q, acc_d;
  logic zero_q, zero_d;
  logic [7:0] intctl_q, intctl_d;
  logic [12:0] pc_q, pc_d;
  logic pop_q, pop_d;
  logic busy_q, busy_d;

  // one-cycle instructions issue only in EXEC; the flush cycle absorbs the pc redirect
  wire logic issue = i_valid && state_q == mnrx_pkg::MNRX_EXEC;
  wire logic [7:0] src = wb.rdata;

  // file port: read address runs ahead so data land in the execute cycle
  assign wb.raddr = i_pre_addr;
  assign wb.we = issue && ((is_copy && dest_file) || is_store);
  assign wb.addr = f_addr;
  assign wb.wdata = is_store ? acc_q : src;

  // next-state for architectural registers
  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    zero_d = zero_q;
    intctl_d = intctl_q;
    pc_d = pc_q;
    pop_d = 1'b0;
    busy_d = 1'b0;
    case (state_q)
      mnrx_pkg::MNRX_EXEC:
      begin
        if (issue)
        begin
          pc_d = pc_q + 13'h0001;
          if (is_copy)
          begin
            if (!dest_file)
              acc_d = src;
            zero_d = src == 8'h00;
          end
          else if (is_lit)
            acc_d = literal;
          else if (is_iret)
          begin
            pc_d = i_stack_top;
            pop_d = 1'b1;
            intctl_d[mnrx_pkg::GIE_BIT] = 1'b1;
            state_d = mnrx_pkg::MNRX_FLUSH;
            busy_d = 1'b1;
          end
        end
      end
      mnrx_pkg::MNRX_FLUSH:
        state_d = mnrx_pkg::MNRX_EXEC;
      default:
        state_d = mnrx_pkg::MNRX_EXEC;
    endcase
  end

  // control registers: state, flush marker and stack pop pulse
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= mnrx_pkg::MNRX_EXEC;
      busy_q <= 1'b0;
      pop_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= busy_d;
      pop_q <= pop_d;
    end
  end

  // working register and zero flag
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      acc_q <= mnrx_pkg::ACC_RESET;
      zero_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      zero_q <= zero_d;
    end
  end

  // program counter and interrupt control
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      intctl_q <= mnrx_pkg::INTCTL_RESET;
      pc_q <= mnrx_pkg::PC_RESET;
    end
    else
    begin
      intctl_q <= intctl_d;
      pc_q <= pc_d;
    end
  end

  // outputs straight from registers; busy has its own flop so no state decode sits on the pin
  assign o_acc = acc_q;
  assign o_zero = zero_q;
  assign o_intctl = intctl_q;
  assign o_pc = pc_q;
  assign o_stack_pop = pop_q;
  assign o_busy = busy_q;

  // one-cycle moves: accumulator, flag and file port
  copy_dest_acc_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_copy && !dest_file |=> o_acc == $past(src))
    else $error("copy to acc wrong");
  copy_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_copy |=> o_zero == ($past(src) == 8'h00))
    else $error("zero flag wrong");
  copy_file_wb_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_copy && dest_file |-> wb.we && wb.addr == f_addr && wb.wdata == src)
    else $error("copy write-back wrong");
  store_noflag_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_store |=> $stable(o_zero) && $stable(o_acc))
    else $error("store changed state");
  store_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_store |-> wb.we && wb.addr == f_addr && wb.wdata == o_acc)
    else $error("store write wrong");
  lit_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_lit |=> o_acc == $past(literal) && $stable(o_zero))
    else $error("literal load wrong");
  lit_no_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_lit |-> !wb.we)
    else $error("literal wrote the file");

  // interrupt return: redirect, pop, allow bit and the dead cycle behind it
  iret_pc_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_iret |=> o_pc == $past(i_stack_top) && o_stack_pop)
    else $error("return pc wrong");
  pop_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_stack_pop |=> !o_stack_pop)
    else $error("stack pop held");
  iret_gie_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_iret |=> o_intctl[mnrx_pkg::GIE_BIT])
    else $error("interrupt allow not set");
  iret_two_cycle_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_iret |=> o_busy ##1 !o_busy)
    else $error("return not two cycles");
  iret_noflag_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_iret |=> $stable(o_zero) && $stable(o_acc))
    else $error("return changed flags");
  flush_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_busy |-> !wb.we ##1 ($stable(o_acc) && $stable(o_zero) && $stable(o_pc)))
    else $error("flush cycle changed state");

  // idle and the common one-cycle timing
  idle_only_pc_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_idle |=> o_pc == $past(o_pc) + 13'h0001 && $stable(o_acc) && $stable(o_zero))
    else $error("idle changed state");
  idle_no_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && is_idle |-> !wb.we ##1 $stable(o_intctl))
    else $error("idle touched the file");
  single_cycle_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && !is_iret |=> !o_busy)
    else $error("single-cycle op stalled");
  pc_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
    issue && !is_iret |=> o_pc == $past(o_pc) + 13'h0001)
    else $error("pc step wrong");

  // scenarios worth seeing: zero copy, write-back copy, store, literal, return then next issue
  copy_cov_c: cover property (@(posedge i_clk) issue && is_copy && src == 8'h00);
  copy_back_cov_c: cover property (@(posedge i_clk) issue && is_copy && dest_file);
  store_cov_c: cover property (@(posedge i_clk) issue && is_store);
  lit_cov_c: cover property (@(posedge i_clk) issue && is_lit);
  iret_cov_c: cover property (@(posedge i_clk) issue && is_iret ##2 issue);
endmodule
`default_nettype wire

// ==== verilog/mnrx_file_mem.sv ====
// mnrx_file_mem: 128 x 8 file register store, registered read data
// assumes the read address is presented one cycle before the data are used
`timescale 1ns/1ns
`default_nettype none
module mnrx_file_mem #(
  parameter int unsigned DEPTH = 128
) (
  // clock
  input wire logic i_clk,
  // access port
  mnrx_wb_if.mem port
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;

  // write-first: a write and a read of one address at one edge hand the new byte on,
  // so a copy issued straight after a store to that register sees the stored value
  wire logic fwd = port.we && port.addr == port.raddr;

  // no reset on the array; contents are software-defined
  always_ff @(posedge i_clk)
  begin
    if (port.we)
      mem_q[port.addr] <= port.wdata;
    rdata_q <= fwd ? port.wdata : mem_q[port.raddr];
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// ==== verilog/mnrx_pkg.sv ====
// mnrx_pkg: opcodes, field layouts and widths for the move/idle/interrupt-return executor
// assumes a 14-bit instruction word with the usual mid-range encoding
package mnrx_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W = 13;
  localparam int unsigned GIE_BIT = 7;
  localparam logic [13:0] OP_IDLE = 14'h0000;
  localparam logic [13:0] OP_IRET = 14'h0009;
  // copy file: 00 1000 d fffffff
  localparam logic [5:0] OP_COPY_HI = 6'h08;
  // store acc: 00 0000 1 fffffff
  localparam logic [6:0] OP_STORE_HI = 7'h01;
  // load literal: 11 00xx kkkkkkkk
  localparam logic [3:0] OP_LIT_HI = 4'hC;
  localparam int unsigned DEST_BIT = 7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam int unsigned IRET_CYCLES = 2;
  typedef enum logic [1:0] {
    MNRX_EXEC = 2'b00,
    MNRX_FLUSH = 2'b01
  } mnrx_state_t;
endpackage

// ==== verilog/mnrx_wb_if.sv ====
// mnrx_wb_if: file-register write-back request from the executor to its register file
// assumes one clock, single write port
`timescale 1ns/1ns
`default_nettype none
interface mnrx_wb_if;
  logic we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport exec (output we, output addr, output wdata, output raddr, input rdata);
  modport mem (input we, input addr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire
